// [src/usm_uart.sv]
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE1: The two length selects give 5, 6, 7 or 8 data bits.
// RULE2: Even parity select high means even parity, low means odd.
// RULE3: Transmit and receive timing clocks run at sixteen times bit rate.
// RULE4: Master reset clears control, status and receive holding; output idles high.
// RULE5: Control load latches parity inhibit, parity sense, stop count, lengths.
// RULE6: Low pulse on hold load captures character and drops hold empty.
// RULE7: Capture on trailing edge; shifter loads on a later falling clock edge.
// RULE8: Empty shifter takes held character behind a start bit on falling edge.
// RULE9: Sends start, 5 to 8 data, optional parity, then stop bits.
// RULE10: Hold empty returns high right after the shifter load.
// RULE11: A queued character starts right after the previous final stop bit.
// RULE12: When all is sent both empty flags are high until the next start.
// RULE13: Each transmitted bit lasts sixteen transmit clock periods.
// RULE14: Falling serial input starts counting; start bit must still be low mid-bit.
// RULE15: Data, parity and stop are sampled at mid-bit; parity and stop checked.
// RULE16: At mid first stop bit the character moves to the holding register.
// RULE17: Unused upper bits of short characters are zero.
// RULE18: Loading while ready is still set raises the overrun flag.
// RULE19: Parity and framing flags and ready become valid after the load.
// RULE20: Status enables follow status disable; data enable follows bus disable.
// RULE21: A low pulse on ready clear drops ready; reception repeats per character.
// RULE22: An asynchronous start edge may be seen one clock tick late.
// RULE23: Parity inhibit removes the parity bit and holds parity flag low.
// RULE24: Stop select gives two stops, or one and a half with five bits.
// RULE25: Framing flag is set when the first stop bit is low.
// RULE26: Serial output stays high when idle; the peer idles serial input high.
// RULE27: Timing ticks come from the 16x clocks; serial input is synchronised.
// RULE28: Error flags change only at the holding-register load and then hold.
//////////////////////////////////////////////////////////////////////////////
module usm_uart
    import usm_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       resetn_in,
    input  wire logic       enable_in,
    input  wire logic       master_reset_in,
    input  wire logic       control_load_in,
    input  wire logic       parity_inhibit_in,
    input  wire logic       even_parity_select_in,
    input  wire logic       stop_bit_select_in,
    input  wire logic       length_select_low_in,
    input  wire logic       length_select_high_in,
    input  wire logic       tx_clock_16x_in,
    input  wire logic       rx_clock_16x_in,
    input  wire logic [7:0] tx_parallel_in,
    input  wire logic       tx_hold_load_n_in,
    input  wire logic       serial_in,
    input  wire logic       rx_ready_clear_n_in,
    input  wire logic       status_output_disable_in,
    input  wire logic       rx_bus_disable_in,
    output logic            serial_out,
    output logic            tx_hold_empty_out,
    output logic            tx_shift_empty_out,
    output logic [7:0]      rx_parallel_out,
    output logic            rx_parallel_oe_n_out,
    output logic            rx_ready_out,
    output logic            overrun_flag_out,
    output logic            parity_flag_out,
    output logic            framing_flag_out,
    output logic            status_oe_n_out
);
    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for asynchronous strobes and serial input.
    logic [1:0] mr_s;
    logic [1:0] crl_s;
    logic [1:0] thl_s;
    logic [1:0] sin_s;
    logic [1:0] clr_s;
    logic       thl_last;
    logic       sin_last;
    logic       clr_req;

    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            mr_s     <= 2'h0;
            crl_s    <= 2'h0;
            thl_s    <= 2'h3;
            sin_s    <= 2'h3;
            clr_s    <= 2'h3;
            thl_last <= 1'b1;
            sin_last <= 1'b1;
        end
        else if (enable_in)
        begin
            mr_s     <= {mr_s[0], master_reset_in};
            crl_s    <= {crl_s[0], control_load_in};
            thl_s    <= {thl_s[0], tx_hold_load_n_in};
            sin_s    <= {sin_s[0], serial_in}; // [RULE27]
            clr_s    <= {clr_s[0], rx_ready_clear_n_in};
            thl_last <= thl_s[1];
            sin_last <= sin_s[1];
        end
    end

    wire mr       = mr_s[1];
    wire thl_rise = thl_s[1] & ~thl_last; // [RULE7]
    assign clr_req = ~clr_s[1]; // [RULE21]

    logic tx_tick;
    logic rx_tick;

    usm_tick u_tx_tick
    (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .enable_in (enable_in),
        .pin_in    (tx_clock_16x_in),
        .tick_out  (tx_tick)
    );

    usm_tick u_rx_tick
    (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .enable_in (enable_in),
        .pin_in    (rx_clock_16x_in),
        .tick_out  (rx_tick)
    );

    //////////////////////////////////////////////////////////////////////////
    // Control register.
    logic [4:0] ctl;

    always_ff @(posedge clock_in)
    begin
        if (!resetn_in || mr) // [RULE4]
            ctl <= CTL_RESET;
        else if (enable_in && crl_s[1]) // [RULE5]
            ctl <= {parity_inhibit_in, even_parity_select_in, stop_bit_select_in,
                    length_select_high_in, length_select_low_in};
    end

    wire [3:0] word_len = usm_len(ctl); // [RULE1]
    wire       par_en   = ~ctl[CTL_PAR_INH]; // [RULE23]
    wire       par_even = ctl[CTL_EVEN];
    wire       two_stop = ctl[CTL_STOP2];

    //////////////////////////////////////////////////////////////////////////
    // Transmitter.
    usm_state_t tx_state;
    logic [7:0] tx_hold;
    logic [7:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [2:0] tx_bit;
    logic       tx_par;
    logic       hold_full;

    wire tx_load   = tx_tick && hold_full && tx_state == USM_IDLE; // [RULE8]
    wire tx_bitend = tx_tick && tx_cnt == LAST_TICK; // [RULE13]
    wire tx_last   = tx_bit == 3'(word_len - 4'h1);
    wire stop2_end = tx_tick &&
                     tx_cnt == ((word_len == 4'h5) ? HALF_BIT_LAST : LAST_TICK); // [RULE24]
    // Parity generator: odd sense inverts the even sum.
    wire par_init  = ~par_even; // [RULE2]
    // A back-to-back load frees the holding register as well.
    wire chain_load = ((tx_state == USM_STOP && tx_bitend && !two_stop) ||
                       (tx_state == USM_STOP2 && stop2_end)) && hold_full;

    always_ff @(posedge clock_in)
    begin
        if (!resetn_in || mr)
        begin
            tx_state  <= USM_IDLE;
            tx_hold   <= DATA_RESET;
            tx_shift  <= DATA_RESET;
            tx_cnt    <= 4'h0;
            tx_bit    <= 3'h0;
            tx_par    <= 1'b0;
            hold_full <= 1'b0;
            serial_out <= 1'b1; // [RULE4]
        end
        else if (enable_in)
        begin
            if (thl_rise)
            begin
                tx_hold   <= tx_parallel_in; // [RULE6] [RULE7]
                hold_full <= 1'b1;
            end
            else if (tx_load || chain_load)
                hold_full <= 1'b0; // [RULE10]
            case (tx_state)
                USM_IDLE:
                begin
                    serial_out <= 1'b1; // [RULE26]
                    if (tx_load)
                    begin
                        tx_shift   <= tx_hold;
                        tx_state   <= USM_START;
                        tx_cnt     <= 4'h0;
                        serial_out <= 1'b0; // [RULE9]
                    end
                end
                USM_START:
                begin
                    if (tx_tick)
                        tx_cnt <= tx_cnt + 4'h1;
                    if (tx_bitend)
                    begin
                        tx_state   <= USM_DATA;
                        tx_bit     <= 3'h0;
                        tx_par     <= par_init ^ tx_shift[0];
                        serial_out <= tx_shift[0];
                        tx_shift   <= {1'b0, tx_shift[7:1]};
                    end
                end
                USM_DATA:
                begin
                    if (tx_tick)
                        tx_cnt <= tx_cnt + 4'h1;
                    if (tx_bitend)
                    begin
                        if (!tx_last)
                        begin
                            tx_bit     <= tx_bit + 3'h1;
                            tx_par     <= tx_par ^ tx_shift[0];
                            serial_out <= tx_shift[0];
                            tx_shift   <= {1'b0, tx_shift[7:1]};
                        end
                        else if (par_en)
                        begin
                            tx_state   <= USM_PARITY;
                            serial_out <= tx_par;
                        end
                        else
                        begin
                            tx_state   <= USM_STOP; // [RULE23]
                            serial_out <= 1'b1;
                        end
                    end
                end
                USM_PARITY:
                begin
                    if (tx_tick)
                        tx_cnt <= tx_cnt + 4'h1;
                    if (tx_bitend)
                    begin
                        tx_state   <= USM_STOP;
                        serial_out <= 1'b1;
                    end
                end
                USM_STOP:
                begin
                    if (tx_tick)
                        tx_cnt <= tx_cnt + 4'h1;
                    if (tx_bitend)
                        tx_state <= two_stop ? USM_STOP2 : USM_IDLE;
                    // Chain straight into the next character to avoid an idle gap.
                    if (tx_bitend && !two_stop && hold_full)
                    begin
                        tx_shift   <= tx_hold; // [RULE11]
                        tx_state   <= USM_START;
                        serial_out <= 1'b0;
                    end
                end
                USM_STOP2:
                begin
                    if (tx_tick)
                        tx_cnt <= stop2_end ? 4'h0 : tx_cnt + 4'h1;
                    if (stop2_end)
                        tx_state <= USM_IDLE;
                    if (stop2_end && hold_full)
                    begin
                        tx_shift   <= tx_hold; // [RULE11]
                        tx_state   <= USM_START;
                        serial_out <= 1'b0;
                    end
                end
                default:
                    tx_state <= USM_IDLE;
            endcase
        end
    end

    assign tx_hold_empty_out  = ~hold_full; // [RULE10]
    assign tx_shift_empty_out = tx_state == USM_IDLE; // [RULE12]

    //////////////////////////////////////////////////////////////////////////
    // Receiver.
    usm_state_t rx_state;
    logic [7:0] rx_shift;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic       rx_par;
    logic [7:0] rx_hold;
    logic       ready;
    logic       overrun;
    logic       par_err;
    logic       frm_err;

    wire sin       = sin_s[1];
    wire rx_fall   = sin_last & ~sin; // [RULE14]
    // The start edge waits for the next receive tick, which may be one late.
    wire rx_mid    = rx_tick && rx_cnt == SAMPLE_POINT; // [RULE15] [RULE22]
    wire rx_last   = rx_bit == 3'(word_len - 4'h1);
    wire [3:0] pad = 4'h8 - word_len;
    wire [7:0] rx_word = rx_shift >> pad; // [RULE17]
    wire rx_store  = rx_state == USM_STOP && rx_mid; // [RULE16]

    always_ff @(posedge clock_in)
    begin
        if (!resetn_in || mr)
        begin
            rx_state <= USM_IDLE;
            rx_shift <= DATA_RESET;
            rx_cnt   <= 4'h0;
            rx_bit   <= 3'h0;
            rx_par   <= 1'b0;
        end
        else if (enable_in)
        begin
            if (rx_tick)
                rx_cnt <= rx_cnt + 4'h1;
            case (rx_state)
                USM_IDLE:
                begin
                    if (rx_fall)
                    begin
                        rx_state <= USM_START;
                        rx_cnt   <= 4'h0;
                    end
                end
                USM_START:
                    if (rx_mid)
                    begin
                        rx_state <= sin ? USM_IDLE : USM_DATA; // [RULE14]
                        rx_bit   <= 3'h0;
                        rx_par   <= par_init;
                    end
                USM_DATA:
                    if (rx_mid)
                    begin
                        rx_shift <= {sin, rx_shift[7:1]};
                        rx_par   <= rx_par ^ sin;
                        rx_bit   <= rx_bit + 3'h1;
                        if (rx_last)
                            rx_state <= par_en ? USM_PARITY : USM_STOP;
                    end
                USM_PARITY:
                    if (rx_mid)
                    begin
                        rx_par   <= rx_par ^ sin; // [RULE2]
                        rx_state <= USM_STOP;
                    end
                USM_STOP:
                    if (rx_mid)
                        rx_state <= USM_IDLE; // [RULE21]
                default:
                    rx_state <= USM_IDLE;
            endcase
        end
    end

    // Error flags update only with the holding load, so they stay stable between characters.
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in || mr) // [RULE4]
        begin
            rx_hold <= DATA_RESET;
            ready   <= 1'b0;
            overrun <= 1'b0;
            par_err <= 1'b0;
            frm_err <= 1'b0;
        end
        else if (enable_in)
        begin
            if (rx_store)
            begin
                rx_hold <= rx_word;
                overrun <= ready; // [RULE18]
                par_err <= par_en & rx_par; // [RULE23] [RULE28]
                frm_err <= ~sin; // [RULE25]
                ready   <= 1'b1; // [RULE19]
            end
            else if (clr_req)
                ready <= 1'b0; // [RULE21]
        end
    end

    assign rx_parallel_out      = rx_hold;
    assign rx_parallel_oe_n_out = rx_bus_disable_in; // [RULE20]
    assign status_oe_n_out      = status_output_disable_in; // [RULE20]
    assign rx_ready_out         = ready;
    assign overrun_flag_out     = overrun;
    assign parity_flag_out      = par_err;
    assign framing_flag_out     = frm_err;
endmodule

// [src/usm_pkg.sv]
package usm_pkg;

    // Oversampling ratio of the 16x timing clocks.
    localparam int          OVERSAMPLE      = 16;
    localparam logic [3:0]  SAMPLE_POINT    = 4'h7;
    localparam logic [3:0]  LAST_TICK       = 4'hF;
    // Half bit for the half stop bit of five-bit words with two stops.
    localparam logic [3:0]  HALF_BIT_LAST   = 4'h7;
    localparam int          WORD_MAX        = 8;
    localparam int          WORD_MIN        = 5;
    // Control register field positions.
    localparam int          CTL_LEN_LOW     = 0;
    localparam int          CTL_LEN_HIGH    = 1;
    localparam int          CTL_STOP2       = 2;
    localparam int          CTL_EVEN        = 3;
    localparam int          CTL_PAR_INH     = 4;
    localparam logic [4:0]  CTL_RESET       = 5'h00;
    localparam logic [7:0]  DATA_RESET      = 8'h00;

    typedef enum logic [2:0]
    {
        USM_IDLE   = 3'b000,
        USM_START  = 3'b001,
        USM_DATA   = 3'b010,
        USM_PARITY = 3'b011,
        USM_STOP   = 3'b100,
        USM_STOP2  = 3'b101
    } usm_state_t;

    // Character length from the two length selects.
    function automatic logic [3:0] usm_len(input logic [4:0] ctl);
        return 4'h5 + {2'b00, ctl[CTL_LEN_HIGH], ctl[CTL_LEN_LOW]};
    endfunction

endpackage

// [src/usm_tick.sv]
`timescale 1ns/10ps
// Turns a 16x timing clock pin into one-cycle ticks on its falling edge.
module usm_tick
    import usm_pkg::*;
(
    input  wire logic clock_in,
    input  wire logic resetn_in,
    input  wire logic enable_in,
    input  wire logic pin_in,
    output logic      tick_out
);
    logic sync1;
    logic sync2;
    logic last;

    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            last  <= 1'b0;
        end
        else if (enable_in)
        begin
            sync1 <= pin_in;
            sync2 <= sync1;
            last  <= sync2;
        end
    end

    assign tick_out = enable_in & last & ~sync2; // [RULE27] [RULE3]
endmodule

// [dv/usm_uart_assertions.sv]
`timescale 1ns/10ps
module usm_uart_assertions
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic tx_clock_16x_in,
    input wire logic rx_ready_clear_n_in,
    input wire logic status_output_disable_in,
    input wire logic rx_bus_disable_in,
    input wire logic serial_out,
    input wire logic tx_hold_empty_out,
    input wire logic tx_shift_empty_out,
    input wire logic rx_ready_out,
    input wire logic overrun_flag_out,
    input wire logic parity_flag_out,
    input wire logic framing_flag_out,
    input wire logic status_oe_n_out,
    input wire logic rx_parallel_oe_n_out
);
    logic       so_prev;
    logic       tck_prev;
    logic [9:0] run_cnt;
    logic       tck_fall;
    logic [9:0] run_len;
    assign tck_fall = tck_prev & ~tx_clock_16x_in;
    assign run_len  = run_cnt + {9'h000, tck_fall};
    // Counting 16x clock falls per level run catches a low bit one tick short or long.
    always_ff @(posedge clock_in)
    begin
        so_prev  <= serial_out;
        tck_prev <= tx_clock_16x_in;
        run_cnt  <= (!resetn_in || serial_out != so_prev) ? 10'h000 : run_len;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking dck @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    AST_DRIVER_EN: assert property (
        {status_oe_n_out, rx_parallel_oe_n_out} == {status_output_disable_in, rx_bus_disable_in})
        else $error("driver enable differs from its disable pin");
    AST_IDLE_HIGH: assert property (
        tx_shift_empty_out && $past(tx_shift_empty_out) |-> serial_out)
        else $error("serial output low while transmitter idle");
    AST_BIT_TICKS: assert property (
        $rose(serial_out) |-> run_len != 10'h000 && run_len[3:0] == 4'h0)
        else $error("low run is not whole bit times");
    AST_LOAD_START: assert property (
        !tx_hold_empty_out && tx_shift_empty_out |-> ##[1:16] !tx_shift_empty_out)
        else $error("held character not moved to idle shifter");
    AST_START_LOW: assert property (
        $fell(tx_shift_empty_out) |-> ##[0:1] !serial_out)
        else $error("no start bit after shifter load");
    AST_HOLD_FREE: assert property (
        $fell(tx_shift_empty_out) |-> ##[0:1] tx_hold_empty_out)
        else $error("holding register not freed after shifter load");
    AST_READY_CLEAR: assert property (
        !rx_ready_clear_n_in [*5] |-> !rx_ready_out)
        else $error("ready not cleared by held clear");
    AST_OVERRUN: assert property (
        $rose(overrun_flag_out) |-> $past(rx_ready_out))
        else $error("overrun raised without pending ready");
    AST_FLAG_HOLD: assert property (
        $changed({parity_flag_out, framing_flag_out}) |->
            $rose(rx_ready_out) || overrun_flag_out || !rx_ready_out)
        else $error("error flags changed outside a load");
    cover property ($rose(rx_ready_out));
    cover property ($rose(overrun_flag_out));
    cover property ($fell(tx_shift_empty_out));
endmodule
bind usm_uart usm_uart_assertions u_chk
(
    .clock_in, .resetn_in, .tx_clock_16x_in, .rx_ready_clear_n_in,
    .status_output_disable_in, .rx_bus_disable_in, .serial_out, .tx_hold_empty_out,
    .tx_shift_empty_out, .rx_ready_out, .overrun_flag_out, .parity_flag_out,
    .framing_flag_out, .status_oe_n_out, .rx_parallel_oe_n_out
);

// [dv/usm_peer.sv]
`timescale 1ns/10ps
module usm_peer
(
    input  wire logic       clock_in,
    input  wire logic       serial_out,
    input  wire logic [3:0] nbits_in,
    input  wire logic       par_en_in,
    output logic            serial_in
);
    logic [9:0] rx_q[$];
    time        t_q[$];
    logic [9:0] w;
    int         i;
    // The line rests high between frames, as a pull-up would leave it.
    initial serial_in = 1'b1;
    ////////////////////////////////////////////////////////////////////////////
    // Bits last 64 system cycles, sixteen 16x clock periods; a short start tests rejection.
    task automatic send(input logic [11:0] f, input int n, input int slen);
        int k;
        for (k = 0; k < n; k++)
        begin
            @(posedge clock_in);
            #1 serial_in = f[k];
            repeat ((k == 0 ? slen : 64) - 1) @(posedge clock_in);
        end
        @(posedge clock_in);
        #1 serial_in = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Records data, parity and first stop bit at mid-bit, plus the start time.
    always
    begin
        @(negedge serial_out);
        t_q.push_back($time);
        w = 10'h000;
        repeat (32) @(posedge clock_in);
        for (i = 0; i <= nbits_in + par_en_in; i++)
        begin
            repeat (64) @(posedge clock_in);
            w[i < nbits_in ? i : (i == nbits_in && par_en_in ? 8 : 9)] = serial_out;
        end
        rx_q.push_back(w);
    end
endmodule

// [dv/usm_uart_test.sv]
`timescale 1ns/10ps
`define CHK(a, e) \
    begin \
        num_checks++; \
        if ((a) !== (e)) \
        begin \
            n_errors++; \
            $display("[ERR] %0t got %0h exp %0h", $time, a, e); \
        end \
    end
module usm_uart_test
    import usm_pkg::*;
;
    logic       clock_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic       master_reset_in = 1'b0;
    logic       control_load_in = 1'b0;
    logic [4:0] cfg_v = 5'h00;
    logic [1:0] div = 2'h0;
    logic [7:0] tx_parallel_in = 8'h00;
    logic       tx_hold_load_n_in = 1'b1;
    logic       rx_ready_clear_n_in = 1'b1;
    logic       status_output_disable_in = 1'b0;
    logic       rx_bus_disable_in = 1'b0;
    logic       serial_in, serial_out, tx_hold_empty_out, tx_shift_empty_out;
    logic       rx_ready_out, overrun_flag_out, parity_flag_out, framing_flag_out;
    logic       rx_parallel_oe_n_out, status_oe_n_out;
    logic [7:0] rx_parallel_out;
    logic [3:0] nb;
    int         n_errors = 0;
    int         num_checks = 0;
    int         c, k;
    logic [4:0] cfg_tab [4] = '{5'h04, 5'h09, 5'h12, 5'h0F};
    logic [7:0] dat_tab [4] = '{8'hF3, 8'h2A, 8'h55, 8'hA7};
    always #50 clock_in = ~clock_in;
    // One shared 16x clock for both directions, a quarter of the system rate.
    always @(posedge clock_in) div <= #1 div + 2'h1;
    assign nb = 4'h5 + {2'h0, cfg_v[CTL_LEN_HIGH], cfg_v[CTL_LEN_LOW]};
    usm_uart dut
    (
        .clock_in,
        .resetn_in,
        .enable_in(1'b1),
        .master_reset_in,
        .control_load_in,
        .parity_inhibit_in(cfg_v[CTL_PAR_INH]),
        .even_parity_select_in(cfg_v[CTL_EVEN]),
        .stop_bit_select_in(cfg_v[CTL_STOP2]),
        .length_select_low_in(cfg_v[CTL_LEN_LOW]),
        .length_select_high_in(cfg_v[CTL_LEN_HIGH]),
        .tx_clock_16x_in(div[1]),
        .rx_clock_16x_in(div[1]),
        .tx_parallel_in,
        .tx_hold_load_n_in,
        .serial_in,
        .rx_ready_clear_n_in,
        .status_output_disable_in,
        .rx_bus_disable_in,
        .serial_out,
        .tx_hold_empty_out,
        .tx_shift_empty_out,
        .rx_parallel_out,
        .rx_parallel_oe_n_out,
        .rx_ready_out,
        .overrun_flag_out,
        .parity_flag_out,
        .framing_flag_out,
        .status_oe_n_out
    );
    usm_peer peer
    (
        .clock_in,
        .serial_out,
        .nbits_in(nb),
        .par_en_in(!cfg_v[CTL_PAR_INH]),
        .serial_in
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic cfg(input logic [4:0] v);
        cfg_v = v;
        control_load_in = 1'b1;
        step(1);
        control_load_in = 1'b0;
    endtask
    task automatic put(input logic [7:0] d);
        tx_parallel_in = d;
        tx_hold_load_n_in = 1'b0;
        step(1);
        tx_hold_load_n_in = 1'b1;
        step(1);
    endtask
    task automatic clear();
        rx_ready_clear_n_in = 1'b0;
        step(6);
        rx_ready_clear_n_in = 1'b1;
        step(1);
    endtask
    task automatic wait_q(input int n);
        int j;
        for (j = 0; j < 3000 && peer.rx_q.size() < n; j++)
            step(1);
        `CHK(peer.rx_q.size() >= n, 1'b1)
    endtask
    // Expected frame: stop bit, parity (zero when inhibited), zero-filled data.
    function automatic logic [9:0] frame_exp(input logic [7:0] d);
        logic [7:0] m;
        m = d & (8'hFF >> (4'h8 - nb));
        return {1'b1, !cfg_v[CTL_PAR_INH] & (^m ^ !cfg_v[CTL_EVEN]), m};
    endfunction
    task automatic rx_chk(input logic [7:0] d, input logic bp, input logic bs);
        logic [11:0] f;
        logic [9:0]  e;
        int          s;
        e = frame_exp(d);
        f = {3'h7, e[7:0], 1'b0};
        s = nb + 1;
        if (!cfg_v[CTL_PAR_INH])
        begin
            f[s] = e[8] ^ bp;
            s = s + 1;
        end
        f[s] = ~bs;
        peer.send(f, s + 1, 64);
        step(4);
        `CHK(rx_parallel_out, e[7:0])
        `CHK(rx_ready_out, 1'b1)
        `CHK({parity_flag_out, framing_flag_out}, {bp & !cfg_v[CTL_PAR_INH], bs})
    endtask
    task automatic finish_test();
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #5000000;
        n_errors++;
        finish_test();
    end
    initial
    begin
        step(2);
        resetn_in = 1'b1;
        step(1);
        `CHK({serial_out, tx_hold_empty_out, tx_shift_empty_out}, 3'h7)
        `CHK({rx_ready_out, overrun_flag_out, parity_flag_out, framing_flag_out}, 4'h0)
        for (c = 0; c < 4; c++)
        begin
            cfg(cfg_tab[c]);
            put(dat_tab[c]);
            wait_q(c + 1);
            `CHK(peer.rx_q[c], frame_exp(dat_tab[c]))
            step(200);
            `CHK({tx_hold_empty_out, tx_shift_empty_out}, 2'h3)
        end
        put(8'h3C);
        for (k = 0; k < 50 && tx_shift_empty_out; k++)
            step(1);
        put(8'hC3);
        step(6);
        `CHK({tx_hold_empty_out, tx_shift_empty_out}, 2'h0)
        wait_q(6);
        `CHK({tx_hold_empty_out, tx_shift_empty_out}, 2'h2)
        `CHK(peer.rx_q[4], frame_exp(8'h3C))
        `CHK(peer.rx_q[5], frame_exp(8'hC3))
        `CHK(peer.t_q[5] - peer.t_q[4], 64'h12C00)
        step(200);
        cfg(5'h09);
        rx_chk(8'hED, 1'b0, 1'b0);
        `CHK(overrun_flag_out, 1'b0)
        clear();
        `CHK(rx_ready_out, 1'b0)
        rx_chk(8'h13, 1'b1, 1'b0);
        rx_chk(8'h0A, 1'b0, 1'b1);
        `CHK(overrun_flag_out, 1'b1)
        cfg(5'h12);
        clear();
        rx_chk(8'hFF, 1'b1, 1'b0);
        clear();
        peer.send(12'hFFE, 1, 12);
        step(1500);
        `CHK(rx_ready_out, 1'b0)
        for (k = 1; k < 3; k++)
        begin
            {status_output_disable_in, rx_bus_disable_in} = k[1:0];
            step(1);
            `CHK({status_oe_n_out, rx_parallel_oe_n_out}, k[1:0])
        end
        rx_chk(8'h6B, 1'b0, 1'b0);
        master_reset_in = 1'b1;
        step(2);
        master_reset_in = 1'b0;
        cfg_v = 5'h00;
        step(5);
        `CHK({rx_ready_out, overrun_flag_out, parity_flag_out, framing_flag_out}, 4'h0)
        `CHK({rx_parallel_out, serial_out}, 9'h001)
        put(8'h35);
        wait_q(7);
        `CHK(peer.rx_q[6], frame_exp(8'h35))
        step(300);
        finish_test();
    end
endmodule
